//--- common/tmr_pkg.sv
package tmr_pkg;

  // ----------------------------------------------------------------
  // Counter range
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [7:0] TMR_MAX = 8'hFF;
  localparam logic [7:0] TMR_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TMR_ADDR_COUNT = 8'h04;
  localparam logic [7:0] TMR_ADDR_CMP = 8'h08;
  localparam logic [7:0] TMR_ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] TMR_ADDR_MASK = 8'h10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int TMR_CS_LSB = 0;
  localparam int TMR_WGM_LSB = 3;
  localparam int TMR_COM_LSB = 5;
  localparam int TMR_FOC_BIT = 7;

  // Flag register fields
  localparam int TMR_OVF_BIT = 0;
  localparam int TMR_CMF_BIT = 1;

  // Mask register field
  localparam int TMR_CIE_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR_RST_BYTE = 8'h00;
  localparam logic [2:0] TMR_CS_STOP = 3'h0;

  // Waveform generation modes
  localparam logic [1:0] TMR_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TMR_WGM_PHASE = 2'h1;
  localparam logic [1:0] TMR_WGM_CTC = 2'h2;
  localparam logic [1:0] TMR_WGM_FAST = 2'h3;

  // Compare output modes
  localparam logic [1:0] TMR_COM_NONE = 2'h0;
  localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMR_COM_SET = 2'h3;

  typedef enum logic {TMR_DIR_UP, TMR_DIR_DOWN} tmr_dir_t;

endpackage

//--- core/tmr_core.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tmr_core (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [7:1] tick_sources, // Tick enables per nonzero select code
  input wire logic global_irq_enable, // Global interrupt enable from status word
  input wire logic irq_ack, // Interrupt serviced pulse
  output logic compare_irq, // Compare interrupt request
  output logic overflow_out, // Overflow flag level
  output logic bottom_out, // Counter at bottom
  output logic max_out, // Counter at maximum
  input wire logic port_data, // General port data value
  input wire logic output_pin_direction_bit, // Port direction bit
  output logic pin_out, // Pin output value
  output logic pin_oe // Pin output enable
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] counter_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic [2:0] clock_select;
    logic [1:0] wave_gen_mode;
    logic [1:0] compare_output_mode;
    logic compare_irq_enable;
    logic compare_match_flag;
    logic overflow_flag;
    logic waveform_output;
    logic block_match;
    tmr_dir_t dir;
    logic [31:0] rdata;
  } tmr_state_t;

  tmr_state_t st;
  tmr_state_t next_st;

  logic timer_tick;
  logic is_pwm;
  logic at_top;
  logic match;
  logic wr_en;
  logic rd_en;

  // PWM modes are the two with the low mode bit set
  function automatic logic pwm_mode(input logic [1:0] m);
    pwm_mode = (m == TMR_WGM_PHASE) || (m == TMR_WGM_FAST);
  endfunction

  // Apply the compare output action for a match
  function automatic logic wave_action(input logic [1:0] com, input logic cur);
    if (com == TMR_COM_TOGGLE) begin
      wave_action = ~cur;
    end else if (com == TMR_COM_CLEAR) begin
      wave_action = 1'b0;
    end else if (com == TMR_COM_SET) begin
      wave_action = 1'b1;
    end else begin
      wave_action = cur;
    end
  endfunction

  // ----------------------------------------------------------------
  // Combinational status
  // ----------------------------------------------------------------
  // Tick is the selected enable; code zero selects nothing
  always_comb begin
    timer_tick = 1'b0;
    if (st.clock_select != TMR_CS_STOP) begin
      timer_tick = tick_sources[st.clock_select];
    end
  end

  assign is_pwm = pwm_mode(st.wave_gen_mode);
  // CTC uses compare as top, otherwise the fixed maximum
  assign at_top = (st.wave_gen_mode == TMR_WGM_CTC) ?
                  (st.counter_value == st.compare_value) :
                  (st.counter_value == TMR_MAX);
  assign match = (st.counter_value == st.compare_value);
  assign bottom_out = (st.counter_value == TMR_BOTTOM);
  assign max_out = (st.counter_value == TMR_MAX);
  assign overflow_out = st.overflow_flag;
  assign compare_irq = st.compare_match_flag & st.compare_irq_enable &
                       global_irq_enable;
  // Port override is independent of mode; direction is left to the port
  assign pin_out = (st.compare_output_mode != TMR_COM_NONE) ?
                   st.waveform_output : port_data;
  assign pin_oe = output_pin_direction_bit;

  assign wr_en = psel & penable & pwrite;
  // Read captured in the setup cycle, so prdata stands through the access phase
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st.rdata;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Order matters: counter write last so it overrides tick updates
  always_comb begin
    next_st = st;
    // Overflow write-one clear goes first so a set by this same tick wins
    if (wr_en && paddr == TMR_ADDR_FLAGS && pwdata[TMR_OVF_BIT]) begin
      next_st.overflow_flag = 1'b0;
    end
    // Tick path
    if (timer_tick) begin
      next_st.block_match = 1'b0;
      if (match && !st.block_match) begin
        next_st.compare_match_flag = 1'b1;
        next_st.waveform_output = wave_action(st.compare_output_mode,
                                              st.waveform_output);
      end
      case (st.wave_gen_mode)
        TMR_WGM_NORMAL: begin
          next_st.counter_value = st.counter_value + TMR_ONE;
          if (st.counter_value == TMR_MAX) begin
            next_st.overflow_flag = 1'b1;
          end
        end
        TMR_WGM_CTC: begin
          if (at_top) begin
            next_st.counter_value = TMR_BOTTOM;
          end else begin
            next_st.counter_value = st.counter_value + TMR_ONE;
          end
          if (st.counter_value == TMR_MAX) begin
            next_st.overflow_flag = 1'b1;
          end
        end
        TMR_WGM_FAST: begin
          if (at_top) begin
            next_st.counter_value = TMR_BOTTOM;
            next_st.compare_value = st.compare_buffer;
            next_st.overflow_flag = 1'b1;
          end else begin
            next_st.counter_value = st.counter_value + TMR_ONE;
          end
        end
        default: begin
          // Dual slope: reverse at max and bottom
          if (st.dir == TMR_DIR_UP) begin
            if (at_top) begin
              next_st.dir = TMR_DIR_DOWN;
              next_st.counter_value = st.counter_value - TMR_ONE;
              next_st.compare_value = st.compare_buffer;
            end else begin
              next_st.counter_value = st.counter_value + TMR_ONE;
            end
          end else begin
            if (bottom_out) begin
              next_st.dir = TMR_DIR_UP;
              next_st.counter_value = st.counter_value + TMR_ONE;
              next_st.overflow_flag = 1'b1;
            end else begin
              next_st.counter_value = st.counter_value - TMR_ONE;
            end
          end
        end
      endcase
    end
    // Interrupt service clears the flag; a new match this cycle still wins
    if (irq_ack && compare_irq && !(timer_tick && match && !st.block_match)) begin
      next_st.compare_match_flag = 1'b0;
    end
    // Register writes
    if (wr_en) begin
      if (paddr == TMR_ADDR_CTRL) begin
        next_st.clock_select = pwdata[TMR_CS_LSB +: 3];
        next_st.wave_gen_mode = pwdata[TMR_WGM_LSB +: 2];
        next_st.compare_output_mode = pwdata[TMR_COM_LSB +: 2];
        if (pwdata[TMR_FOC_BIT] && !pwm_mode(pwdata[TMR_WGM_LSB +: 2])) begin
          next_st.waveform_output = wave_action(pwdata[TMR_COM_LSB +: 2],
                                                st.waveform_output);
        end
        if (pwm_mode(pwdata[TMR_WGM_LSB +: 2]) != is_pwm) begin
          next_st.dir = TMR_DIR_UP;
        end
      end else if (paddr == TMR_ADDR_COUNT) begin
        next_st.counter_value = pwdata[7:0];
        next_st.block_match = 1'b1;
      end else if (paddr == TMR_ADDR_CMP) begin
        next_st.compare_buffer = pwdata[7:0];
        if (!is_pwm) begin
          next_st.compare_value = pwdata[7:0];
        end
      end else if (paddr == TMR_ADDR_FLAGS) begin
        // Set by a tick in the same cycle wins over the clear
        if (pwdata[TMR_CMF_BIT] && !(timer_tick && match && !st.block_match)) begin
          next_st.compare_match_flag = 1'b0;
        end
      end else if (paddr == TMR_ADDR_MASK) begin
        next_st.compare_irq_enable = pwdata[TMR_CIE_BIT];
      end
    end
    // Read data capture; unmapped reads return zero
    next_st.rdata = '0;
    if (rd_en) begin
      if (paddr == TMR_ADDR_CTRL) begin
        next_st.rdata[TMR_CS_LSB +: 3] = st.clock_select;
        next_st.rdata[TMR_WGM_LSB +: 2] = st.wave_gen_mode;
        next_st.rdata[TMR_COM_LSB +: 2] = st.compare_output_mode;
      end else if (paddr == TMR_ADDR_COUNT) begin
        next_st.rdata[7:0] = st.counter_value;
      end else if (paddr == TMR_ADDR_CMP) begin
        next_st.rdata[7:0] = is_pwm ? st.compare_buffer : st.compare_value;
      end else if (paddr == TMR_ADDR_FLAGS) begin
        next_st.rdata[TMR_OVF_BIT] = st.overflow_flag;
        next_st.rdata[TMR_CMF_BIT] = st.compare_match_flag;
      end else if (paddr == TMR_ADDR_MASK) begin
        next_st.rdata[TMR_CIE_BIT] = st.compare_irq_enable;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Read data registered at setup, so it stands during the zero-wait access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && paddr == TMR_ADDR_COUNT |=> st.counter_value == $past(pwdata[7:0]))
    else $error("counter write lost");

  a_match_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && paddr == TMR_ADDR_COUNT && !st.compare_match_flag && !timer_tick |=>
    st.block_match && !st.compare_match_flag)
    else $error("match not blocked after counter write");

  a_flag_on_match: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_tick && match && !st.block_match |=> st.compare_match_flag)
    else $error("compare flag not set");

  a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && st.clock_select == TMR_CS_STOP && !wr_en |=> $stable(st.counter_value))
    else $error("counter moved while stopped");

  a_normal_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_tick && st.wave_gen_mode == TMR_WGM_NORMAL && max_out && !wr_en
    |=> bottom_out && st.overflow_flag)
    else $error("normal wrap wrong");

  a_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_tick && st.wave_gen_mode == TMR_WGM_CTC && match && !wr_en
    |=> st.counter_value == TMR_BOTTOM)
    else $error("ctc did not clear");

  a_fast_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_tick && st.wave_gen_mode == TMR_WGM_FAST && max_out && !wr_en
    |=> bottom_out && st.overflow_flag)
    else $error("fast mode restart wrong");

  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && paddr == TMR_ADDR_FLAGS && pwdata[TMR_CMF_BIT] && !timer_tick
    |=> !st.compare_match_flag)
    else $error("flag clear failed");

  a_port_override: assert property (@(posedge pclk) disable iff (!presetn)
    st.compare_output_mode != TMR_COM_NONE |-> pin_out == st.waveform_output)
    else $error("port override missing");

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    compare_irq |-> st.compare_match_flag && st.compare_irq_enable && global_irq_enable)
    else $error("irq without cause");

  a_buffered_cmp: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && is_pwm && !(timer_tick && at_top) |=> $stable(st.compare_value))
    else $error("compare updated off top");

  // ----------------------------------------------------------------
  // Flag, compare, counting, force and output checks
  // ----------------------------------------------------------------
  a_ack_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && irq_ack && compare_irq && !timer_tick |=> !st.compare_match_flag)
    else $error("serviced flag not cleared");

  a_force_wave: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && paddr == TMR_ADDR_CTRL && pwdata[TMR_FOC_BIT] &&
    !pwm_mode(pwdata[TMR_WGM_LSB +: 2]) && pwdata[TMR_COM_LSB +: 2] == TMR_COM_SET
    |=> st.waveform_output)
    else $error("forced set missing");

  a_force_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && paddr == TMR_ADDR_CTRL && pwdata[TMR_FOC_BIT] && !timer_tick &&
    !irq_ack |=> $stable(st.compare_match_flag) && $stable(st.counter_value))
    else $error("force touched flag or counter");

  a_cmp_direct: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && paddr == TMR_ADDR_CMP && !is_pwm |=>
    st.compare_value == $past(pwdata[7:0]))
    else $error("direct compare write lost");

  a_mode_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && paddr == TMR_ADDR_CTRL && !pwdata[TMR_FOC_BIT] && !timer_tick
    |=> $stable(st.waveform_output))
    else $error("mode change moved output");

  a_com_none: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_tick && st.compare_output_mode == TMR_COM_NONE &&
    !(wr_en && paddr == TMR_ADDR_CTRL) |=> $stable(st.waveform_output))
    else $error("output moved with mode zero");

  a_up_step: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_tick && st.wave_gen_mode == TMR_WGM_NORMAL && !max_out && !wr_en
    |=> st.counter_value == $past(st.counter_value) + TMR_ONE)
    else $error("normal step wrong");

  a_fast_load: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_tick && st.wave_gen_mode == TMR_WGM_FAST && at_top && !wr_en
    |=> st.compare_value == $past(st.compare_buffer))
    else $error("buffer not loaded at top");

  a_block_tick: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_tick && st.block_match && !st.compare_match_flag |=>
    !st.compare_match_flag)
    else $error("blocked tick set flag");

  a_tick_only: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && st.clock_select != TMR_CS_STOP && !timer_tick && !wr_en |=>
    $stable(st.counter_value))
    else $error("counter moved without tick");

endmodule

//--- testbench/tmr_tick_src.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side: prescaler tick enables and the pad with its pull-up
// ----------------------------------------------------------------
module tmr_tick_src #(
  parameter int GAP = 2
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic go, // Emit ticks while high
  input wire logic [2:0] sel, // Source line that pulses
  input wire logic pin_out, // Pin value from the timer
  input wire logic pin_oe, // Timer drives the pad when high
  output logic [7:1] tick_sources, // One-cycle tick enables
  output logic pin_level // Level seen on the pad
);
  int cnt;

  // Pulses spaced GAP+1 cycles; GAP of two or more keeps a stop
  // request from the bench from racing one last pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= GAP;
      tick_sources <= 7'h00;
    end else begin
      cnt <= (!go || cnt == 0) ? GAP : cnt - 1;
      for (int i = 1; i < 8; i++) begin
        tick_sources[i] <= go && cnt == 0 && sel == 3'(i);
      end
    end
  end

  // Undriven pad floats to the pull-up, never the last value
  assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

//--- testbench/tmr_core_tb_top.sv
`timescale 1ns/1ps
`define CK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end
module tmr_core_tb_top;
  import tmr_pkg::*;
  logic pclk = 1'b0;
  logic presetn, clk_en, psel, penable, pwrite, global_irq_enable, irq_ack;
  logic port_data, output_pin_direction_bit, go, pready, pslverr, compare_irq;
  logic overflow_out, bottom_out, max_out, pin_out, pin_oe, pin_level;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  logic [7:1] tick_sources;
  logic [2:0] tsel;
  int n_ticks, n_mismatch, tests_run;

  tmr_core i_tmr_core (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tick_sources(tick_sources),
    .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .compare_irq(compare_irq),
    .overflow_out(overflow_out), .bottom_out(bottom_out), .max_out(max_out),
    .port_data(port_data), .output_pin_direction_bit(output_pin_direction_bit),
    .pin_out(pin_out), .pin_oe(pin_oe));
  tmr_tick_src i_tmr_tick_src (.pclk(pclk), .presetn(presetn), .go(go), .sel(tsel),
    .pin_out(pin_out), .pin_oe(pin_oe), .tick_sources(tick_sources), .pin_level(pin_level));

  // ----------------------------------------------------------------
  // Clock, tick count and bus helpers
  // ----------------------------------------------------------------
  always #5 pclk = ~pclk;

  // Counts tick pulses seen by the timer
  always_ff @(posedge pclk) begin
    if (|tick_sources) n_ticks <= n_ticks + 1;
  end

  // Read data is taken at the edge where pready is sampled high; one idle
  // edge follows so the next call never reassigns psel in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CK(nm, e, q)
  endtask

  function automatic logic [7:0] cv(input logic [2:0] c, input logic [1:0] m,
    input logic [1:0] o, input logic f);
    return {f, o, m, c};
  endfunction

  task automatic tk(input int n);
    int t0;
    t0 = n_ticks;
    go <= 1'b1;
    while (n_ticks < t0 + n) @(posedge pclk);
    go <= 1'b0;
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 24; a += 4) rc("reset reg", 8'(a), 8'h00);
    `CK("bottom", 1'b1, bottom_out)
    `CK("max", 1'b0, max_out)
    wr(8'h14, 8'hAA);
    rc("unmapped", 8'h14, 8'h00);
    `CK("slverr", 1'b0, pslverr)
  endtask

  task automatic t_sources();
    for (int c = 1; c < 8; c++) begin
      tsel <= 3'(c);
      wr(TMR_ADDR_CTRL, cv(3'(c), TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
      wr(TMR_ADDR_COUNT, 8'h00);
      tk(1);
      rc("step", TMR_ADDR_COUNT, 8'h01);
      tsel <= 3'(c % 7 + 1);
      tk(2);
      rc("other src", TMR_ADDR_COUNT, 8'h01);
    end
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
    tsel <= 3'h1;
    tk(2);
    rc("stopped", TMR_ADDR_COUNT, 8'h01);
  endtask

  task automatic t_wrap();
    int t0;
    wr(TMR_ADDR_CTRL, cv(3'h1, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
    wr(TMR_ADDR_FLAGS, 8'hFF);
    wr(TMR_ADDR_COUNT, 8'hFE);
    tk(1);
    `CK("max", 1'b1, max_out)
    rc("cnt max", TMR_ADDR_COUNT, 8'hFF);
    tk(1);
    `CK("ovf", 1'b1, overflow_out)
    `CK("bottom", 1'b1, bottom_out)
    rc("flags", TMR_ADDR_FLAGS, 8'h01);
    // Write lands on the very edge of a tick
    t0 = n_ticks;
    go <= 1'b1;
    while (n_ticks == t0) @(posedge pclk);
    wr(TMR_ADDR_COUNT, 8'h55);
    go <= 1'b0;
    rc("prio", TMR_ADDR_COUNT, 8'h55);
  endtask

  task automatic t_ctc();
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
    wr(TMR_ADDR_FLAGS, 8'hFF);
    wr(TMR_ADDR_CMP, 8'h03);
    wr(TMR_ADDR_COUNT, 8'h00);
    wr(TMR_ADDR_CTRL, cv(3'h1, TMR_WGM_CTC, TMR_COM_TOGGLE, 1'b0));
    tk(4);
    rc("ctc clr", TMR_ADDR_COUNT, 8'h00);
    `CK("toggle", 1'b1, pin_out)
    rc("ctc flag", TMR_ADDR_FLAGS, 8'h02);
  endtask

  task automatic t_cmp();
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
    wr(TMR_ADDR_FLAGS, 8'hFF);
    wr(TMR_ADDR_CMP, 8'h05);
    wr(TMR_ADDR_COUNT, 8'h03);
    wr(TMR_ADDR_CTRL, cv(3'h1, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
    tk(2);
    rc("no flag yet", TMR_ADDR_FLAGS, 8'h00);
    tk(1);
    rc("flag", TMR_ADDR_FLAGS, 8'h02);
    wr(TMR_ADDR_FLAGS, 8'h00);
    rc("w0 keeps", TMR_ADDR_FLAGS, 8'h02);
    wr(TMR_ADDR_MASK, 8'h02);
    global_irq_enable <= 1'b1;
    @(posedge pclk);
    `CK("irq", 1'b1, compare_irq)
    global_irq_enable <= 1'b0;
    @(posedge pclk);
    `CK("irq gie", 1'b0, compare_irq)
    wr(TMR_ADDR_FLAGS, 8'h02);
    rc("w1 clears", TMR_ADDR_FLAGS, 8'h00);
    wr(TMR_ADDR_COUNT, 8'h04);
    tk(2);
    global_irq_enable <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    rc("ack clears", TMR_ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_block();
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
    wr(TMR_ADDR_CMP, 8'h10);
    // Deliberately equal to compare while stopped
    wr(TMR_ADDR_COUNT, 8'h10);
    wr(TMR_ADDR_FLAGS, 8'hFF);
    wr(TMR_ADDR_CTRL, cv(3'h1, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
    tk(1);
    rc("blocked", TMR_ADDR_FLAGS, 8'h00);
    rc("counted", TMR_ADDR_COUNT, 8'h11);
  endtask

  task automatic t_force();
    wr(TMR_ADDR_FLAGS, 8'hFF);
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_CLEAR, 1'b1));
    `CK("f clear", 1'b0, pin_out)
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_SET, 1'b1));
    `CK("f set", 1'b1, pin_out)
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_TOGGLE, 1'b1));
    `CK("f toggle", 1'b0, pin_out)
    rc("f noflag", TMR_ADDR_FLAGS, 8'h00);
    rc("f nocnt", TMR_ADDR_COUNT, 8'h11);
    port_data <= 1'b1;
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b1));
    `CK("port data", 1'b1, pin_out)
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_SET, 1'b0));
    `CK("none kept", 1'b0, pin_out)
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_SET, 1'b1));
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_FAST, TMR_COM_SET, 1'b0));
    `CK("mode kept", 1'b1, pin_out)
    rc("ctrl", TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_FAST, TMR_COM_SET, 1'b0));
    // Output state is settled before the pad turns around
    output_pin_direction_bit <= 1'b1;
    @(posedge pclk);
    `CK("oe", 1'b1, pin_oe)
    `CK("pad", 1'b1, pin_level)
    // Low port data tells the driven pad apart from the pull-up
    port_data <= 1'b0;
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_FAST, TMR_COM_NONE, 1'b0));
    `CK("pad low", 1'b0, pin_level)
    output_pin_direction_bit <= 1'b0;
    @(posedge pclk);
    `CK("oe off", 1'b0, pin_oe)
    `CK("pad pulled", 1'b1, pin_level)
  endtask

  task automatic t_buf();
    wr(TMR_ADDR_CMP, 8'h40);
    rc("buffer", TMR_ADDR_CMP, 8'h40);
    wr(TMR_ADDR_COUNT, 8'h0E);
    wr(TMR_ADDR_FLAGS, 8'hFF);
    wr(TMR_ADDR_CTRL, cv(3'h1, TMR_WGM_FAST, TMR_COM_NONE, 1'b0));
    tk(3);
    rc("old active", TMR_ADDR_FLAGS, 8'h02);
    wr(TMR_ADDR_COUNT, 8'hFE);
    wr(TMR_ADDR_FLAGS, 8'hFF);
    tk(2);
    rc("fast ovf", TMR_ADDR_FLAGS, 8'h01);
    wr(TMR_ADDR_COUNT, 8'h3E);
    wr(TMR_ADDR_FLAGS, 8'hFF);
    tk(3);
    rc("new active", TMR_ADDR_FLAGS, 8'h02);
    wr(TMR_ADDR_CTRL, cv(TMR_CS_STOP, TMR_WGM_PHASE, TMR_COM_NONE, 1'b0));
    wr(TMR_ADDR_COUNT, 8'hFE);
    wr(TMR_ADDR_CTRL, cv(3'h1, TMR_WGM_PHASE, TMR_COM_NONE, 1'b0));
    tk(3);
    rc("down", TMR_ADDR_COUNT, 8'hFD);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, global_irq_enable, irq_ack, port_data, go} = 7'h00;
    {presetn, output_pin_direction_bit, paddr, pwdata} = '0;
    clk_en = 1'b1;
    tsel = 3'h1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_sources();
    t_wrap();
    t_ctc();
    t_cmp();
    t_block();
    t_force();
    t_buf();
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles; reaching 30000 means a hang
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
